// ---- src/sib_top.sv ----
// The address-and-strobe port was chosen for this implementation.
`default_nettype none
`include "sib_cfg.svh"
//------------------------------------------------------------
// self-id buffer tracking
//------------------------------------------------------------
// Overview of operation
// - base pointer bits 31..11 read/write
// - base bits 10..0 ignore writes, read zero
// - store self-id packets at base address
// - fault flag bit 31 on reception error
// - clean reception clears fault flag
// - packet errors and write failures both fault
// - generation bits 23..16 count resets, wrap
// - quadlet count bits 10..2, header included
// - quadlet count clears at reception start
// - count reserved bits read zero
module sib_top
   import sib_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata,
   // link receive side
   input  wire logic        bus_reset,
   input  wire logic        rx_start,
   input  wire logic [31:0] rx_header,
   input  wire logic        rx_valid,
   input  wire logic [31:0] rx_data,
   input  wire logic        rx_end,
   input  wire logic        rx_error,
   output logic             rx_ready,
   // host memory
   output logic             mem_wr_req,
   output logic [31:0]      mem_wr_addr,
   output logic [31:0]      mem_wr_data,
   input  wire logic        mem_wr_ack,
   input  wire logic        mem_wr_err
);
   sib_state_t  state_q;
   logic [20:0] base_q;
   logic        fault_q;
   logic        pend_fault_q;
   logic [7:0]  gen_q;
   logic [8:0]  size_q;
   logic        issued_q;
   logic        end_seen_q;
   logic [31:0] hdr_q;
   logic [31:0] word_q;
   logic        word_ok_q;
   sib_wr_if    wr ();

   //------------------------------------------------------------
   // helpers
   //------------------------------------------------------------
   // starts are honoured only from idle; one mid-reception is lost
   function automatic logic take_start(input sib_state_t st,
                                       input logic       start);
      return (st == SIB_IDLE) && start;
   endfunction : take_start

   //------------------------------------------------------------
   // register file
   //------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         base_q <= `SIB_BASE_RST;
      end else if (reg_wr && reg_addr == `SIB_OFS_BASE) begin
         base_q <= reg_wdata[31:`SIB_BASE_LSB];
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_rd) begin
         unique case (reg_addr)
            `SIB_OFS_BASE:  reg_rdata <= {base_q, 11'h000};
            `SIB_OFS_COUNT: reg_rdata <= {fault_q, 7'h00, gen_q,
                                          5'h00, size_q, 2'h0};
            default:        reg_rdata <= 32'h00000000;
         endcase
      end else begin
         reg_rdata <= 32'h00000000;
      end
   end

   //------------------------------------------------------------
   // generation counter
   //------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         gen_q <= `SIB_GEN_RST;
      end else if (bus_reset) begin
         gen_q <= gen_q + 8'h01;
      end
   end

   //------------------------------------------------------------
   // reception sequencer
   //------------------------------------------------------------
   // one word in flight at a time; rx_ready stalls the link meanwhile
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q    <= SIB_IDLE;
         hdr_q      <= 32'h00000000;
         word_q     <= 32'h00000000;
         word_ok_q  <= 1'b0;
         issued_q   <= 1'b0;
         end_seen_q <= 1'b0;
         rx_ready   <= 1'b0;
      end else begin
         unique case (state_q)
            SIB_IDLE: begin
               if (rx_start) begin
                  hdr_q      <= rx_header;
                  state_q    <= SIB_HDR;
                  issued_q   <= 1'b0;
                  end_seen_q <= 1'b0;
                  rx_ready   <= 1'b0;
               end
            end
            SIB_HDR: begin
               if (!issued_q) begin
                  issued_q <= 1'b1;
               end else if (wr.done || wr.fail) begin
                  issued_q <= 1'b0;
                  state_q  <= SIB_DATA;
                  rx_ready <= 1'b1;
               end
            end
            SIB_DATA: begin
               if (word_ok_q) begin
                  if (!issued_q) begin
                     issued_q <= 1'b1;
                  end else if (wr.done || wr.fail) begin
                     issued_q  <= 1'b0;
                     word_ok_q <= 1'b0;
                     // the end branch next cycle closes out and settles fault
                     rx_ready  <= !end_seen_q;
                  end
               end else if (end_seen_q) begin
                  state_q  <= SIB_IDLE;
                  rx_ready <= 1'b0;
               end else if (rx_ready && rx_valid) begin
                  word_q     <= rx_data;
                  word_ok_q  <= 1'b1;
                  end_seen_q <= rx_end;
                  rx_ready   <= 1'b0;
               end else if (rx_ready && rx_end) begin
                  end_seen_q <= 1'b1;
                  rx_ready   <= 1'b0;
               end
            end
            default: begin
               state_q  <= SIB_IDLE;
               rx_ready <= 1'b0;
            end
         endcase
      end
   end

   // header at base, data words follow at consecutive addresses
   assign wr.req  = (state_q == SIB_HDR || (state_q == SIB_DATA
                    && word_ok_q)) && !issued_q;
   assign wr.addr = {base_q, 11'h000} + {21'h000000, size_q, 2'h0};
   assign wr.data = (state_q == SIB_HDR) ? hdr_q : word_q;

   //------------------------------------------------------------
   // quadlet count and fault flag
   //------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         size_q <= `SIB_SIZE_RST;
      end else if (take_start(state_q, rx_start)) begin
         size_q <= `SIB_SIZE_RST;
      end else if (wr.done) begin
         size_q <= size_q + 9'h001;
      end
   end

   // fault of the running reception is latched until it ends
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pend_fault_q <= 1'b0;
         fault_q      <= 1'b0;
      end else if (take_start(state_q, rx_start)) begin
         pend_fault_q <= 1'b0;
      end else if (state_q != SIB_IDLE) begin
         if (rx_error || wr.fail) begin
            pend_fault_q <= 1'b1;
            fault_q      <= 1'b1;
         end else if (state_q == SIB_DATA && end_seen_q && !word_ok_q) begin
            fault_q <= pend_fault_q;
         end
      end
   end

   sib_wr_port u_wr (
      .clk         (clk),
      .rst_b       (rst_b),
      .wr          (wr),
      .mem_wr_req  (mem_wr_req),
      .mem_wr_addr (mem_wr_addr),
      .mem_wr_data (mem_wr_data),
      .mem_wr_ack  (mem_wr_ack),
      .mem_wr_err  (mem_wr_err)
   );

   //------------------------------------------------------------
   // checks
   //------------------------------------------------------------
   AST_GEN_WRAP: assert property (
      @(posedge clk) disable iff (!rst_b)
      bus_reset |=> gen_q == $past(gen_q) + 8'h01)
      else $error("generation did not step");

   AST_GEN_HOLD: assert property (
      @(posedge clk) disable iff (!rst_b)
      !bus_reset |=> $stable(gen_q))
      else $error("generation moved without bus reset");

   AST_BASE_RD: assert property (
      @(posedge clk) disable iff (!rst_b)
      reg_rd && reg_addr == `SIB_OFS_BASE |=> reg_rdata[10:0] == 11'h000)
      else $error("base low bits not zero");

   AST_BASE_HI: assert property (
      @(posedge clk) disable iff (!rst_b)
      reg_rd && reg_addr == `SIB_OFS_BASE
      |=> reg_rdata[31:11] == $past(base_q))
      else $error("base read differs from stored pointer");

   AST_BASE_WR: assert property (
      @(posedge clk) disable iff (!rst_b)
      reg_wr && reg_addr == `SIB_OFS_BASE
      |=> base_q == $past(reg_wdata[31:11]))
      else $error("base write lost");

   AST_CNT_RSVD: assert property (
      @(posedge clk) disable iff (!rst_b)
      reg_rd && reg_addr == `SIB_OFS_COUNT |=> reg_rdata[30:24] == 7'h00
      && reg_rdata[15:11] == 5'h00 && reg_rdata[1:0] == 2'h0)
      else $error("count reserved bits set");

   AST_CNT_FIELDS: assert property (
      @(posedge clk) disable iff (!rst_b)
      reg_rd && reg_addr == `SIB_OFS_COUNT
      |=> reg_rdata[31] == $past(fault_q)
      && reg_rdata[23:16] == $past(gen_q)
      && reg_rdata[10:2] == $past(size_q))
      else $error("count fields differ from state");

   //------------------------------------------------------------
   // reception checks
   //------------------------------------------------------------
   AST_SIZE_CLR: assert property (
      @(posedge clk) disable iff (!rst_b)
      state_q == SIB_IDLE && rx_start |=> size_q == 9'h000)
      else $error("size not cleared");

   AST_SIZE_INC: assert property (
      @(posedge clk) disable iff (!rst_b)
      wr.done && !(state_q == SIB_IDLE) |=> size_q == $past(size_q) + 9'h001)
      else $error("size not counted");

   AST_SIZE_HOLD: assert property (
      @(posedge clk) disable iff (!rst_b)
      !wr.done && !(state_q == SIB_IDLE && rx_start) |=> $stable(size_q))
      else $error("size moved without a written quadlet");

   AST_FAULT_SET: assert property (
      @(posedge clk) disable iff (!rst_b)
      state_q != SIB_IDLE && (rx_error || wr.fail) |=> fault_q)
      else $error("fault not raised");

   AST_FAIL_PEND: assert property (
      @(posedge clk) disable iff (!rst_b)
      state_q != SIB_IDLE && wr.fail |=> pend_fault_q)
      else $error("write failure not kept for the reception");

   AST_FAULT_CLR: assert property (
      @(posedge clk) disable iff (!rst_b)
      state_q != SIB_IDLE ##1 (state_q == SIB_IDLE && !pend_fault_q)
      |-> !fault_q)
      else $error("clean reception left fault set");

   AST_FAULT_KEEP: assert property (
      @(posedge clk) disable iff (!rst_b)
      state_q != SIB_IDLE && pend_fault_q |-> fault_q)
      else $error("fault dropped during reception");

   AST_HDR_ADDR: assert property (
      @(posedge clk) disable iff (!rst_b)
      wr.req && state_q == SIB_HDR |-> wr.addr == {base_q, 11'h000})
      else $error("header not at base");

   AST_HDR_FIRST: assert property (
      @(posedge clk) disable iff (!rst_b)
      state_q == SIB_HDR |-> !rx_ready)
      else $error("data accepted before header written");

   AST_WR_BASE: assert property (
      @(posedge clk) disable iff (!rst_b)
      $rose(mem_wr_req) |-> mem_wr_addr[31:11] == base_q
      && mem_wr_addr[1:0] == 2'h0)
      else $error("buffer write outside base window");

   AST_WR_HOLD: assert property (
      @(posedge clk) disable iff (!rst_b)
      mem_wr_req && !mem_wr_ack && !mem_wr_err |=> mem_wr_req
      && $stable(mem_wr_addr) && $stable(mem_wr_data))
      else $error("buffer write dropped before answer");
endmodule : sib_top
`default_nettype wire

// ---- src/sib_cfg.svh ----
`ifndef SIB_CFG_SVH
`define SIB_CFG_SVH
// register byte offsets
`define SIB_OFS_BASE      8'h64
`define SIB_OFS_COUNT     8'h68
// field positions
`define SIB_BASE_LSB      11
`define SIB_ERR_BIT       31
`define SIB_GEN_LSB       16
`define SIB_SIZE_LSB      2
// reset values
`define SIB_BASE_RST      21'h000000
`define SIB_GEN_RST       8'h00
`define SIB_SIZE_RST      9'h000
`endif

// ---- src/sib_pkg.sv ----
`default_nettype none
package sib_pkg;
   typedef enum logic [1:0] {
      SIB_IDLE,
      SIB_HDR,
      SIB_DATA
   } sib_state_t;
endpackage : sib_pkg
`default_nettype wire

// ---- src/sib_wr_if.sv ----
`default_nettype none
interface sib_wr_if;
   logic        req;
   logic [31:0] addr;
   logic [31:0] data;
   logic        done;
   logic        fail;
   modport src (output req, output addr, output data,
                input done, input fail);
   modport dst (input req, input addr, input data,
                output done, output fail);
endinterface : sib_wr_if
`default_nettype wire

// ---- src/sib_wr_port.sv ----
`default_nettype none
`include "sib_cfg.svh"
// registered host-memory write master: holds each request until done/fail
module sib_wr_port
   import sib_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // internal side
   sib_wr_if.dst            wr,
   // host memory bus
   output logic             mem_wr_req,
   output logic [31:0]      mem_wr_addr,
   output logic [31:0]      mem_wr_data,
   input  wire logic        mem_wr_ack,
   input  wire logic        mem_wr_err
);
   logic busy_q;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         busy_q      <= 1'b0;
         mem_wr_req  <= 1'b0;
         mem_wr_addr <= 32'h00000000;
         mem_wr_data <= 32'h00000000;
      end else if (!busy_q && wr.req) begin
         busy_q      <= 1'b1;
         mem_wr_req  <= 1'b1;
         mem_wr_addr <= wr.addr;
         mem_wr_data <= wr.data;
      end else if (busy_q && (mem_wr_ack || mem_wr_err)) begin
         busy_q     <= 1'b0;
         mem_wr_req <= 1'b0;
      end
   end

   assign wr.done = busy_q && mem_wr_ack && !mem_wr_err;
   assign wr.fail = busy_q && mem_wr_err;
endmodule : sib_wr_port
`default_nettype wire

// ---- bench/sib_mem_model.sv ----
`default_nettype none
// --------------------------------------------------
// host memory: answers each held write after lag
// --------------------------------------------------
module sib_mem_model (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_b,
   // write handshake
   input  wire logic       mem_wr_req,
   output logic            mem_wr_ack,
   output logic            mem_wr_err,
   // test controls
   input  wire logic [1:0] lag,
   input  wire logic       fail
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] wait_q;
   // an answered request is not answered again while it drops
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mem_wr_ack <= 1'b0;
         mem_wr_err <= 1'b0;
         wait_q     <= 2'h0;
      end else begin
         mem_wr_ack <= 1'b0;
         mem_wr_err <= 1'b0;
         if (mem_wr_req && !mem_wr_ack && !mem_wr_err) begin
            wait_q <= (wait_q == lag) ? 2'h0 : wait_q + 2'h1;
            mem_wr_ack <= (wait_q == lag) && !fail;
            mem_wr_err <= (wait_q == lag) && fail;
         end
      end
   end
endmodule : sib_mem_model
`default_nettype wire

// ---- bench/test_sib_top.sv ----
`default_nettype none
`include "sib_cfg.svh"
module test_sib_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst_b, reg_wr, reg_rd, bus_reset, rx_start, rx_end;
   logic        rx_valid, rx_error, rx_ready, fail, rd_d, track, fault_m;
   logic        mem_wr_req, mem_wr_ack, mem_wr_err;
   logic [1:0]  lag;
   logic [7:0]  reg_addr, gen_m;
   logic [31:0] reg_wdata, reg_rdata, rx_header, rx_data, base_m;
   logic [31:0] mem_wr_addr, mem_wr_data;
   logic [63:0] rdq[$], wrq[$];
   integer      seed = 72, n_mismatch = 0, checked = 0, k;
   sib_top DUT (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .bus_reset, .rx_start, .rx_header, .rx_valid, .rx_data,
      .rx_end, .rx_error, .rx_ready, .mem_wr_req, .mem_wr_addr,
      .mem_wr_data, .mem_wr_ack, .mem_wr_err);
   sib_mem_model mem (.clk, .rst_b, .mem_wr_req, .mem_wr_ack, .mem_wr_err,
      .lag, .fail);
   always #12.5 clk = ~clk;
   // --------------------------------------------------
   // shared tasks
   // --------------------------------------------------
   task check(input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task end_sim;
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_sim
   function logic [31:0] cnt_v(input logic [8:0] size);
      return {fault_m, 7'h00, gen_m, 5'h00, size, 2'h0};
   endfunction : cnt_v
   task wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      rdq.push_back({m, e});
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
   endtask : rd
   task pulse_reset;
      bus_reset <= 1'b1;
      @(posedge clk);
      bus_reset <= 1'b0;
      @(posedge clk);
      gen_m++;
   endtask : pulse_reset
   // header, then n words; the last carries rx_end
   task recv(input integer n, input logic perr);
      logic [31:0] w;
      integer      t;
      w = $random(seed);
      if (track) wrq.push_back({base_m, w});
      rx_header <= w;
      rx_start <= 1'b1;
      @(posedge clk);
      rx_start <= 1'b0;
      @(posedge clk);
      rd(`SIB_OFS_COUNT, cnt_v(9'h000), 32'hFFFFFFFF);
      rx_error <= perr;
      for (k = 1; k <= n; k++) begin
         w = $random(seed);
         if (track) wrq.push_back({base_m + 32'(4 * k), w});
         rx_data <= w;
         rx_valid <= 1'b1;
         rx_end <= (k == n);
         t = 0;
         do begin
            @(posedge clk);
            rx_error <= 1'b0;
            t++;
         end while (rx_ready !== 1'b1 && t < 60);
         check(rx_ready, 1'b1);
      end
      rx_valid <= 1'b0;
      rx_end <= 1'b0;
      // the last word's write is only requested two edges on
      repeat (2) @(posedge clk);
      for (t = 0; t < 300 && (wrq.size() > 0 || mem_wr_req !== 1'b0); t++)
         @(posedge clk);
      check(mem_wr_req, 1'b0);
      repeat (4) @(posedge clk);
   endtask : recv
   // --------------------------------------------------
   // result monitor
   // --------------------------------------------------
   always @(posedge clk) begin
      if (rd_d) begin
         check(reg_rdata & rdq[0][63:32], rdq[0][31:0] & rdq[0][63:32]);
         void'(rdq.pop_front());
      end
      if (mem_wr_ack === 1'b1 && track) begin
         check({mem_wr_addr, mem_wr_data}, wrq[0]);
         void'(wrq.pop_front());
      end
      rd_d <= reg_rd;
   end
   initial begin
      #200000;
      n_mismatch++;
      end_sim;
   end
   // --------------------------------------------------
   // main sequence
   // --------------------------------------------------
   initial begin
      {clk, rst_b, fail, fault_m, lag, gen_m} = '0;
      {reg_wr, reg_rd, bus_reset, rx_start, rx_valid, rx_end, rx_error} = '0;
      {reg_addr, reg_wdata, rx_header, rx_data} = '0;
      track = 1'b1;
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rd(`SIB_OFS_COUNT, 32'h00000000, 32'hFFFFFFFF);
      wr(`SIB_OFS_BASE, 32'hFFFFFFFF);
      rd(`SIB_OFS_BASE, 32'hFFFFF800, 32'hFFFFFFFF);
      wr(`SIB_OFS_COUNT, 32'hFFFFFFFF);
      rd(`SIB_OFS_COUNT, 32'h00000000, 32'hFFFFFFFF);
      rd(8'h6C, 32'h00000000, 32'hFFFFFFFF);
      base_m = $random(seed) & 32'hFFFFF800;
      wr(`SIB_OFS_BASE, base_m | 32'h000007FF);
      rd(`SIB_OFS_BASE, base_m, 32'hFFFFFFFF);
      $display("register test done");
      pulse_reset;
      lag <= 2'h3;
      recv(3, 1'b0);
      rd(`SIB_OFS_COUNT, cnt_v(9'h004), 32'hFFFFFFFF);
      $display("clean reception test done");
      track = 1'b0;
      recv(2, 1'b1);
      fault_m = 1'b1;
      rd(`SIB_OFS_COUNT, cnt_v(9'h000), 32'hFFFFF803);
      track = 1'b1;
      lag <= 2'h0;
      recv(1, 1'b0);
      fault_m = 1'b0;
      rd(`SIB_OFS_COUNT, cnt_v(9'h002), 32'hFFFFFFFF);
      track = 1'b0;
      fail <= 1'b1;
      recv(2, 1'b0);
      fault_m = 1'b1;
      rd(`SIB_OFS_COUNT, cnt_v(9'h000), 32'hFFFFF803);
      $display("fault test done");
      track = 1'b1;
      fail <= 1'b0;
      lag <= 2'($random(seed));
      pulse_reset;
      recv(5, 1'b0);
      fault_m = 1'b0;
      rd(`SIB_OFS_COUNT, cnt_v(9'h006), 32'hFFFFFFFF);
      for (integer j = 0; j < 256; j++) begin
         pulse_reset;
         if (gen_m == 8'hFF || gen_m == 8'h00)
            rd(`SIB_OFS_COUNT, cnt_v(9'h000), 32'hFFFFF803);
      end
      $display("generation test done");
      repeat (4) @(posedge clk);
      end_sim;
   end
endmodule : test_sib_top
`default_nettype wire
